// *** rtl/dso_delay.v ***
// Purpose: level follower with separate rise and fall delays
// Assumes: din synchronous to clk
// Notes:   dout takes din after it differed for N cycles in a row
`timescale 1ns/100ps
module dso_delay #(
  parameter          CW     = 26,
  parameter [CW-1:0] N_RISE = {{(CW-1){1'b0}}, 1'b1},
  parameter [CW-1:0] N_FALL = {{(CW-1){1'b0}}, 1'b1}
) (
  input  wire clk,
  input  wire rst_n,
  input  wire din,
  output reg  dout
);

  reg  [CW-1:0] cnt_reg;
  wire [CW-1:0] target;

  // a glitch shorter than the delay restarts the count
  assign target = din ? N_RISE : N_FALL;

  // count while input and output disagree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= {CW{1'b0}};
      dout    <= 1'b0;
    end else if (din == dout) begin
      cnt_reg <= {CW{1'b0}};
    end else if (cnt_reg == target - {{(CW-1){1'b0}}, 1'b1}) begin
      cnt_reg <= {CW{1'b0}};
      dout    <= din;
    end else begin
      cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule

// *** rtl/dso_map.vh ***
// Purpose: constants for the data switch over-voltage sequencer
// Assumes: 50 MHz pclk, APB register window of 32-bit words
// Notes:   times kept in us and ms, cycle counts derived from them
`ifndef DSO_MAP_VH
`define DSO_MAP_VH

// timebase
`define DSO_CLK_MHZ       50
`define DSO_SW_ON_US      800
`define DSO_SW_ON_CYC     (`DSO_SW_ON_US * `DSO_CLK_MHZ)
`define DSO_PG_US         100
`define DSO_PG_CYC        (`DSO_PG_US * `DSO_CLK_MHZ)
`define DSO_FAST_US       5
`define DSO_FAST_CYC      (`DSO_FAST_US * `DSO_CLK_MHZ)
`define DSO_BRST_MS       400
`define DSO_BRST_CYC      (`DSO_BRST_MS * 1000 * `DSO_CLK_MHZ)

// register byte offsets
`define DSO_CTRL_OFS      12'h000
`define DSO_STAT_OFS      12'h004
`define DSO_INT_STAT_OFS  12'h008
`define DSO_INT_MASK_OFS  12'h00C

// control fields
`define DSO_CTRL_MODE_LSB 0
`define DSO_CTRL_MODE_MSB 1
`define DSO_CTRL_RST      2'h0

// charging mode encodings
`define DSO_MODE_SDP      2'h0
`define DSO_MODE_CDP      2'h1
`define DSO_MODE_DCP      2'h2

// live status fields
`define DSO_STAT_SW       0
`define DSO_STAT_PG       1
`define DSO_STAT_OVP      2
`define DSO_STAT_BRST     3
`define DSO_STAT_POR      4
`define DSO_STAT_W        5

// interrupt status / mask fields
`define DSO_INT_OVP_ON    0
`define DSO_INT_OVP_OFF   1
`define DSO_INT_BRST_DONE 2
`define DSO_INT_W         3
`define DSO_INT_MASK_RST  3'h0

`endif

// *** rtl/dso_sequencer.v ***
// Purpose: data pass switch, over-voltage and bus reset sequencing
// Assumes: comparator and supply pins are asynchronous levels
// Notes:   APB slave answers with one wait-free access phase
`timescale 1ns/100ps
`include "dso_map.vh"

// Notes on behaviour
// - switch stays closed only while mode is CDP or SDP.
// - switch closes 800 us after supply reaches power-on level.
// - switch opens as soon as supply drops below power-on level.
// - power-good goes low 100 us after a data-line over-voltage.
// - switch opens 5 us after a data-line over-voltage.
// - fault state holds while any data line stays over threshold.
// - after fault clears, power-good back in 100 us, switch in 5 us.
// - power-good rising edge starts a 400 ms output bus reset.
// - bus reset: converter off, discharge bus, converter back on.
module dso_sequencer #(
  parameter AW      = 12,
  parameter CW      = 26,
  parameter SW_ON_C = `DSO_SW_ON_CYC,
  parameter PG_C    = `DSO_PG_CYC,
  parameter FAST_C  = `DSO_FAST_CYC,
  parameter BRST_C  = `DSO_BRST_CYC
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          supply_por_ok,
  input  wire          ovp_data_pos,
  input  wire          ovp_data_neg,
  input  wire          power_good_level,
  input  wire          bus_at_safe_level,
  output reg           data_switch_on,
  output reg           power_good_out,
  output reg           converter_enable,
  output reg           bus_discharge_en,
  output reg           irq
);

  // bus reset states, one-hot
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_OFF   = 4'h2;
  localparam [3:0] ST_DISCH = 4'h4;
  localparam [3:0] ST_WAIT  = 4'h8;

  // register select codes
  localparam [3:0] SEL_CTRL = 4'h1;
  localparam [3:0] SEL_STAT = 4'h2;
  localparam [3:0] SEL_INTS = 4'h4;
  localparam [3:0] SEL_INTM = 4'h8;

  // counts cut to the counter width on purpose; CW must hold BRST_C
  localparam [CW-1:0] SW_ON_N = SW_ON_C[CW-1:0];
  localparam [CW-1:0] PG_N    = PG_C[CW-1:0];
  localparam [CW-1:0] FAST_N  = FAST_C[CW-1:0];
  localparam [CW-1:0] BRST_N  = BRST_C[CW-1:0];
  localparam [CW-1:0] ONE_N   = {{(CW-1){1'b0}}, 1'b1};

  // address decode shared by read and write paths
  function [3:0] reg_sel;
    input [AW-1:0] addr;
    begin
      case (addr)
        `DSO_CTRL_OFS:     reg_sel = SEL_CTRL;
        `DSO_STAT_OFS:     reg_sel = SEL_STAT;
        `DSO_INT_STAT_OFS: reg_sel = SEL_INTS;
        `DSO_INT_MASK_OFS: reg_sel = SEL_INTM;
        default:           reg_sel = 4'h0;
      endcase
    end
  endfunction

  wire [4:0]  pins_s;
  wire        por_s;
  wire        ovp_pos_s;
  wire        ovp_neg_s;
  wire        pg_lvl_s;
  wire        bus_safe_s;
  wire        ovp_any;
  wire        por_dly;
  wire        sw_block;
  wire        pg_block;
  wire        mode_pass;
  wire [3:0]  sel;
  wire        wr_en;
  wire        pg_next;
  wire        pg_rise;
  wire        sw_next;
  wire [`DSO_INT_W-1:0] int_evt;
  wire [`DSO_STAT_W-1:0] live_stat;

  reg  [1:0]  mode_reg;
  reg  [`DSO_INT_W-1:0] int_stat_reg;
  reg  [`DSO_INT_W-1:0] int_stat_next;
  reg  [`DSO_INT_W-1:0] int_mask_reg;
  reg         sw_block_reg;
  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg  [CW-1:0] brst_cnt_reg;
  reg  [CW-1:0] brst_cnt_next;
  reg         brst_done;
  reg  [31:0] rdata_next;

  // pin levels cross into pclk before any counter sees them
  dso_sync #(
    .W (5)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   ({bus_at_safe_level, power_good_level, ovp_data_neg,
             ovp_data_pos, supply_por_ok}),
    .dout  (pins_s)
  );

  assign por_s      = pins_s[0];
  assign ovp_pos_s  = pins_s[1];
  assign ovp_neg_s  = pins_s[2];
  assign pg_lvl_s   = pins_s[3];
  assign bus_safe_s = pins_s[4];

  // either data line over threshold counts as a fault
  assign ovp_any = ovp_pos_s | ovp_neg_s;

  // supply up: long delay before closing; supply down: next cycle
  dso_delay #(
    .CW     (CW),
    .N_RISE (SW_ON_N),
    .N_FALL (ONE_N)
  ) u_por_dly (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (por_s),
    .dout  (por_dly)
  );

  // fast path: switch follows the fault both ways in 5 us
  dso_delay #(
    .CW     (CW),
    .N_RISE (FAST_N),
    .N_FALL (FAST_N)
  ) u_sw_dly (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (ovp_any),
    .dout  (sw_block)
  );

  // slow path: power-good follows the fault both ways in 100 us
  dso_delay #(
    .CW     (CW),
    .N_RISE (PG_N),
    .N_FALL (PG_N)
  ) u_pg_dly (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (ovp_any),
    .dout  (pg_block)
  );

  // DCP keeps the data lines away from the host
  assign mode_pass = (mode_reg == `DSO_MODE_SDP) ||
                     (mode_reg == `DSO_MODE_CDP);

  // switch closed only with supply settled, pass mode, no fault
  assign sw_next = por_dly & mode_pass & ~sw_block;

  // power-good gated by the fault and by the regulator level
  assign pg_next = pg_lvl_s & ~pg_block;
  assign pg_rise = pg_next & ~power_good_out;

  // pin outputs, all registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_switch_on <= 1'b0;
      power_good_out <= 1'b0;
      sw_block_reg   <= 1'b0;
    end else begin
      data_switch_on <= sw_next;
      power_good_out <= pg_next;
      sw_block_reg   <= sw_block;
    end
  end

  // bus reset sequencer next state
  always @* begin
    state_next    = state_reg;
    brst_cnt_next = brst_cnt_reg;
    brst_done     = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        brst_cnt_next = {CW{1'b0}};
        if (pg_rise) begin
          state_next = ST_OFF;
        end
      end
      ST_OFF: begin
        // converter is switched off a cycle before discharge starts
        brst_cnt_next = brst_cnt_reg + ONE_N;
        state_next    = ST_DISCH;
      end
      ST_DISCH: begin
        brst_cnt_next = brst_cnt_reg + ONE_N;
        if (brst_cnt_reg == BRST_N - ONE_N) begin
          state_next = ST_IDLE;
          brst_done  = 1'b1;
        end else if (bus_safe_s) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        brst_cnt_next = brst_cnt_reg + ONE_N;
        if (brst_cnt_reg == BRST_N - ONE_N) begin
          state_next = ST_IDLE;
          brst_done  = 1'b1;
        end
      end
      default: begin
        state_next    = ST_IDLE;
        brst_cnt_next = {CW{1'b0}};
      end
    endcase
  end

  // sequencer state and converter controls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg        <= ST_IDLE;
      brst_cnt_reg     <= {CW{1'b0}};
      converter_enable <= 1'b1;
      bus_discharge_en <= 1'b0;
    end else begin
      state_reg        <= state_next;
      brst_cnt_reg     <= brst_cnt_next;
      converter_enable <= (state_next == ST_IDLE);
      bus_discharge_en <= (state_next == ST_DISCH);
    end
  end

  // interrupt events: fault entry, fault exit, bus reset finished
  assign int_evt[`DSO_INT_OVP_ON]    = sw_block & ~sw_block_reg;
  assign int_evt[`DSO_INT_OVP_OFF]   = ~sw_block & sw_block_reg;
  assign int_evt[`DSO_INT_BRST_DONE] = brst_done;

  assign live_stat[`DSO_STAT_SW]   = data_switch_on;
  assign live_stat[`DSO_STAT_PG]   = power_good_out;
  assign live_stat[`DSO_STAT_OVP]  = sw_block_reg;
  assign live_stat[`DSO_STAT_BRST] = ~state_reg[0];
  assign live_stat[`DSO_STAT_POR]  = por_dly;

  // APB access phase completes while pready is high
  assign sel   = reg_sel(paddr);
  assign wr_en = psel & penable & pready & pwrite;

  // write-one-to-clear; a new event in the same cycle wins
  always @* begin
    int_stat_next = int_stat_reg;
    if (wr_en && sel == SEL_INTS) begin
      int_stat_next = int_stat_reg & ~pwdata[`DSO_INT_W-1:0];
    end
    int_stat_next = int_stat_next | int_evt;
  end

  // read mux, sampled in the setup cycle
  always @* begin
    rdata_next = 32'h0000_0000;
    case (sel)
      SEL_CTRL: rdata_next[1:0] = mode_reg;
      SEL_STAT: rdata_next[`DSO_STAT_W-1:0] = live_stat;
      SEL_INTS: rdata_next[`DSO_INT_W-1:0] = int_stat_reg;
      SEL_INTM: rdata_next[`DSO_INT_W-1:0] = int_mask_reg;
      default:  rdata_next = 32'h0000_0000;
    endcase
  end

  // APB slave and software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= 32'h0000_0000;
      mode_reg     <= `DSO_CTRL_RST;
      int_stat_reg <= {`DSO_INT_W{1'b0}};
      int_mask_reg <= `DSO_INT_MASK_RST;
      irq          <= 1'b0;
    end else begin
      // one access cycle per transfer, ready set from the setup
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (sel == 4'h0);
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_next;
      end
      if (wr_en && sel == SEL_CTRL) begin
        mode_reg <= pwdata[`DSO_CTRL_MODE_MSB:`DSO_CTRL_MODE_LSB];
      end
      if (wr_en && sel == SEL_INTM) begin
        int_mask_reg <= pwdata[`DSO_INT_W-1:0];
      end
      int_stat_reg <= int_stat_next;
      irq          <= |(int_stat_next & int_mask_reg);
    end
  end

endmodule

// *** rtl/dso_sync.v ***
// Purpose: two-stage synchroniser for a group of pin levels
// Assumes: inputs are slow levels, not multi-bit words
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module dso_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      // two flops per bit, cleared by reset
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= din[i];
          sync_reg <= meta_reg;
        end
      end
      assign dout[i] = sync_reg;
    end
  endgenerate

endmodule

// *** verif/dso_bus_model.sv ***
// Purpose: output bus seen by the sequencer during a bus reset
// Assumes: bus falls only while converter off and discharge on
// Notes:   slow fall of DIS_C cycles, so discharge must really hold
`timescale 1ns/100ps
module dso_bus_model #(
  parameter DIS_C = 6
) (
  input  wire logic pclk,
  input  wire logic converter_enable,
  input  wire logic bus_discharge_en,
  output wire logic bus_at_safe_level
);
  logic [7:0] fall_cnt = 8'h0;

  // converter on recharges the bus at once; discharge pulls it down
  always @(posedge pclk) begin
    if (converter_enable)
      fall_cnt <= 8'h0;
    else if (bus_discharge_en && fall_cnt < DIS_C)
      fall_cnt <= fall_cnt + 8'h1;
  end
  assign bus_at_safe_level = !converter_enable && fall_cnt >= DIS_C;
endmodule

// *** verif/dso_sequencer_properties.sv ***
// Purpose: concurrent checks on the sequencer pins
// Assumes: one clock domain, counts passed in by bind
// Notes:   counters give exact figures; sync lag of ~3 edges allowed
`timescale 1ns/100ps
module dso_sequencer_properties #(
  parameter SW_ON_C = 40,
  parameter PG_C    = 20,
  parameter FAST_C  = 5,
  parameter BRST_C  = 100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic supply_por_ok,
  input wire logic ovp_data_pos,
  input wire logic ovp_data_neg,
  input wire logic data_switch_on,
  input wire logic power_good_out,
  input wire logic converter_enable,
  input wire logic bus_discharge_en
);
  logic [31:0] sup_cnt, ovp_cnt, ok_cnt, off_cnt;
  wire         ovp = ovp_data_pos | ovp_data_neg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // run lengths of steady pin levels, no saturation: runs are short
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_cnt <= 32'h0;
      ovp_cnt <= 32'h0;
      ok_cnt  <= 32'h0;
      off_cnt <= 32'h0;
    end else begin
      sup_cnt <= supply_por_ok ? sup_cnt + 32'h1 : 32'h0;
      ovp_cnt <= ovp ? ovp_cnt + 32'h1 : 32'h0;
      ok_cnt  <= ovp ? 32'h0 : ok_cnt + 32'h1;
      off_cnt <= converter_enable ? 32'h0 : off_cnt + 32'h1;
    end
  end

  a_switch_wait: assert property ($rose(data_switch_on) |->
    sup_cnt >= SW_ON_C) else $error("switch closed early");
  a_switch_drop: assert property (!supply_por_ok [*6] |->
    !data_switch_on) else $error("switch kept on without supply");
  a_pg_fault: assert property (ovp_cnt > PG_C + 4 |->
    !power_good_out) else $error("power good high in fault");
  a_switch_fault: assert property (ovp_cnt > FAST_C + 4 |->
    !data_switch_on) else $error("switch on in fault");
  a_fault_hold: assert property ($rose(power_good_out) |->
    ok_cnt >= PG_C) else $error("power good released early");
  a_switch_back: assert property ($rose(data_switch_on) |->
    ok_cnt >= FAST_C) else $error("switch back too early");
  a_reset_start: assert property ($rose(power_good_out) |=>
    !converter_enable) else $error("bus reset not started");
  a_reset_length: assert property ($rose(converter_enable) |->
    off_cnt >= BRST_C - 1 && off_cnt <= BRST_C + 2)
    else $error("bus reset length wrong");
  a_discharge_off: assert property (bus_discharge_en |->
    !converter_enable) else $error("discharge with converter on");
  // an unsynchronised path would open the switch two edges sooner
  a_sync_lag: assert property ($fell(supply_por_ok)
    && data_switch_on |=> data_switch_on [*2]) else $error("no sync lag");

  c_fault: cover property ($fell(power_good_out));
  c_reset_end: cover property ($rose(converter_enable));
  c_supply_off: cover property ($fell(data_switch_on) && !ovp);
endmodule

bind dso_sequencer dso_sequencer_properties #(.SW_ON_C(SW_ON_C),
  .PG_C(PG_C), .FAST_C(FAST_C), .BRST_C(BRST_C))
  dso_sequencer_properties_i (.pclk(pclk), .presetn(presetn),
  .supply_por_ok(supply_por_ok), .ovp_data_pos(ovp_data_pos),
  .ovp_data_neg(ovp_data_neg), .data_switch_on(data_switch_on),
  .power_good_out(power_good_out), .converter_enable(converter_enable),
  .bus_discharge_en(bus_discharge_en));

// *** verif/test_dso_sequencer.sv ***
// Purpose: self-checking bench for the data switch sequencer
// Assumes: shortened counts, pins driven as slow levels
// Notes:   pins packed as {switch, power good, converter, irq}
`timescale 1ns/100ps
`include "dso_map.vh"
module test_dso_sequencer;
  localparam SW = 40, PG = 20, FA = 5, BR = 100;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic        pwrite = 0, sup = 0, op = 0, on = 0, lvl = 0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, safe, sw, pg, conv, dis, irq;
  int          n_errors = 0, samples_checked = 0, cycles = 0;

  dso_sequencer #(.SW_ON_C(SW), .PG_C(PG), .FAST_C(FA), .BRST_C(BR))
    dso_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_por_ok(sup), .ovp_data_pos(op), .ovp_data_neg(on),
    .power_good_level(lvl), .bus_at_safe_level(safe),
    .data_switch_on(sw), .power_good_out(pg), .converter_enable(conv),
    .bus_discharge_en(dis), .irq(irq));
  dso_bus_model dso_bus_model_i (.pclk(pclk), .converter_enable(conv),
    .bus_discharge_en(dis), .bus_at_safe_level(safe));

  always #10 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] seen, x);
    samples_checked++;
    if (seen !== x) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, x, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // settle past the edge, so next drive needs cyc or apb first
  task automatic pins(input logic [3:0] x);
    #1 chk("pins", {sw, pg, conv, irq}, x);
  endtask
  // request held until pready seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    apb(1'h0, a, 32'h0);
    chk("rdata", q, x);
    chk("slverr", e, xe);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, run needs about 680 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 3000) begin
      n_errors++;
      close_out;
    end
  end

  initial begin
    cyc(2);
    presetn <= 1'h1;
    pins(4'h2);
    rd(`DSO_CTRL_OFS, 32'h0, 1'h0);
    rd(`DSO_INT_MASK_OFS, 32'h0, 1'h0);
    rd(12'h010, 32'h0, 1'h1);
    sup <= 1'h1;
    cyc(25);
    pins(4'h2);
    cyc(5);
    lvl <= 1'h1;
    cyc(30);
    pins(4'hC);
    cyc(90);
    pins(4'hE);
    // each data line in turn, irq masked off throughout
    for (int i = 0; i < 2; i++) begin
      cyc(1);
      op <= (i == 0);
      on <= (i == 1);
      cyc(FA + 6);
      pins(4'h6);
      cyc(PG);
      pins(4'h2);
      cyc(30);
      pins(4'h2);
      rd(`DSO_STAT_OFS, (32'h1 << `DSO_STAT_OVP) |
         (32'h1 << `DSO_STAT_POR), 1'h0);
      cyc(1);
      op <= 1'h0;
      on <= 1'h0;
      cyc(FA + 6);
      pins(4'hA);
      cyc(PG);
      pins(4'hC);
      chk("discharge", dis, 32'h1);
      cyc(110);
      pins(4'hE);
      chk("discharge", dis, 32'h0);
      rd(`DSO_INT_STAT_OFS, 32'h7, 1'h0);
    end
    apb(1'h1, `DSO_INT_MASK_OFS, 32'h1);
    cyc(2);
    pins(4'hF);
    apb(1'h1, `DSO_INT_STAT_OFS, 32'h7);
    cyc(2);
    pins(4'hE);
    apb(1'h1, `DSO_CTRL_OFS, {30'h0, `DSO_MODE_CDP});
    cyc(10);
    pins(4'hE);
    apb(1'h1, `DSO_CTRL_OFS, {30'h0, `DSO_MODE_DCP});
    cyc(10);
    pins(4'h6);
    apb(1'h1, `DSO_CTRL_OFS, {30'h0, `DSO_MODE_SDP});
    cyc(SW + 10);
    pins(4'hE);
    cyc(1);
    sup <= 1'h0;
    cyc(6);
    pins(4'h6);
    close_out;
  end
endmodule
